// ---- rtl/scrsel_pkg.sv ----
package scrsel_pkg;

   // Configured scrambler mode for one link direction.
   typedef enum logic [2:0] {
      SCRSEL_MODE_OFF = 3'h0,
      SCRSEL_MODE_AUTO = 3'h1,
      SCRSEL_MODE_RULE_A = 3'h2,
      SCRSEL_MODE_RULE_B = 3'h3,
      SCRSEL_MODE_V35 = 3'h4,
      SCRSEL_MODE_SELFSYNC = 3'h5,
      SCRSEL_MODE_ALT_V35 = 3'h6,
      SCRSEL_MODE_ALT_SELFSYNC = 3'h7
   } scrsel_mode_t;

   // Resolved scrambler type driven to the data path.
   typedef enum logic [2:0] {
      SCRSEL_TYPE_NONE = 3'h0,
      SCRSEL_TYPE_V35 = 3'h1,
      SCRSEL_TYPE_SELFSYNC = 3'h2,
      SCRSEL_TYPE_MUX_SYNC = 3'h3,
      SCRSEL_TYPE_RS_SYNC = 3'h4,
      SCRSEL_TYPE_RESERVED = 3'h5,
      SCRSEL_TYPE_SPARE = 3'h6,
      SCRSEL_TYPE_TURBO_SYNC = 3'h7
   } scrsel_type_t;

   localparam logic [2:0] SCRSEL_RESET_TYPE = 3'h0;
   localparam logic SCRSEL_RESET_INVERT = 1'b0;

endpackage

// ---- rtl/scrsel_resolve.sv ----
`timescale 1ns/1ps
// Combinational resolver for one link direction.
module scrsel_resolve (
   input wire logic [2:0] i_mode, // Configured mode.
   input wire logic i_turbo_product_code_enable, // Turbo coding on.
   input wire logic i_framing_mux_enable, // Framing multiplexer on.
   input wire logic i_reed_solomon_enable, // Reed-Solomon on.
   input wire logic i_auto_rule_set_b, // Auto uses the second rule set.
   output logic [2:0] o_type, // Resolved scrambler type.
   output logic o_invert // Data inversion request.
);

   // Applies one standard rule set to the mux and coding settings.
   function automatic logic [2:0] rule_set(input logic set_b, input logic mux,
                                           input logic rs);
      logic [2:0] t;
      t = scrsel_pkg::SCRSEL_TYPE_SELFSYNC;
      if (mux) begin
         t = scrsel_pkg::SCRSEL_TYPE_MUX_SYNC;
      end else if (rs && !set_b) begin
         t = scrsel_pkg::SCRSEL_TYPE_RS_SYNC;
      end
      return t;
   endfunction

   // Resolves the mode into a type and inversion.
   always_comb begin
      o_type = scrsel_pkg::SCRSEL_TYPE_NONE;
      o_invert = 1'b0;
      case (i_mode)
         scrsel_pkg::SCRSEL_MODE_AUTO: begin
            if (!i_turbo_product_code_enable) begin
               o_type = rule_set(i_auto_rule_set_b, i_framing_mux_enable,
                                 i_reed_solomon_enable);
            end else if (!i_framing_mux_enable) begin
               o_type = scrsel_pkg::SCRSEL_TYPE_TURBO_SYNC;
            end else begin
               // turbo with mux uses set A.
               o_type = rule_set(1'b0, i_framing_mux_enable, i_reed_solomon_enable);
            end
         end
         scrsel_pkg::SCRSEL_MODE_RULE_A: begin
            o_type = rule_set(1'b0, i_framing_mux_enable, i_reed_solomon_enable);
         end
         scrsel_pkg::SCRSEL_MODE_RULE_B: begin
            o_type = rule_set(1'b1, i_framing_mux_enable, i_reed_solomon_enable);
         end
         scrsel_pkg::SCRSEL_MODE_V35: begin
            o_type = scrsel_pkg::SCRSEL_TYPE_V35;
         end
         scrsel_pkg::SCRSEL_MODE_SELFSYNC: begin
            o_type = scrsel_pkg::SCRSEL_TYPE_SELFSYNC;
         end
         scrsel_pkg::SCRSEL_MODE_ALT_V35: begin
            o_type = scrsel_pkg::SCRSEL_TYPE_V35;
            o_invert = 1'b1;
         end
         scrsel_pkg::SCRSEL_MODE_ALT_SELFSYNC: begin
            o_type = scrsel_pkg::SCRSEL_TYPE_SELFSYNC;
            o_invert = 1'b1;
         end
         default: begin
            o_type = scrsel_pkg::SCRSEL_TYPE_NONE;
         end
      endcase
   end

endmodule // scrsel_resolve

// ---- rtl/scrsel_top.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - In auto mode without turbo coding, one of the two standard rule sets picks the type.
// - In auto mode with turbo coding and no multiplexer, the turbo sync scrambler is used.
// - In auto mode with turbo coding and the multiplexer, the first rule set applies.
// - Under the first set with no mux and no Reed-Solomon, self-sync scrambling is used.
// - Under the first set with only the mux, the mux sync scrambler is used.
// - Under the first set with only Reed-Solomon, the Reed-Solomon sync scrambler is used.
// - Under the first set with mux and Reed-Solomon, the mux sync scrambler is used.
// - The second set matches the first except that Reed-Solomon alone gives self-sync.
// - The fixed modes always use their own scrambler, V.35 or self-synchronizing.
// - The alternate modes also invert the data.
// - Transmit and receive modes are separate settings resolved separately.
module scrsel_top (
   input wire logic i_clk, // System clock, 50 MHz.
   input wire logic i_rst_b, // Asynchronous reset, active low.
   input wire logic [2:0] i_tx_mode, // Transmit scrambler mode.
   input wire logic [2:0] i_rx_mode, // Receive descrambler mode.
   input wire logic i_turbo_product_code_enable, // Turbo coding enabled.
   input wire logic i_framing_mux_enable, // Framing multiplexer enabled.
   input wire logic i_reed_solomon_enable, // Reed-Solomon enabled.
   input wire logic i_auto_rule_set_b, // Auto picks second rule set.
   output logic [2:0] o_tx_type, // Transmit scrambler type.
   output logic o_tx_invert, // Transmit data inversion.
   output logic [2:0] o_rx_type, // Receive descrambler type.
   output logic o_rx_invert // Receive data inversion.
);

   logic [2:0] tx_type_c;
   logic [2:0] rx_type_c;
   logic tx_inv_c;
   logic rx_inv_c;
   logic [2:0] tx_type_d, tx_type_q, rx_type_d, rx_type_q;
   logic tx_inv_d, tx_inv_q, rx_inv_d, rx_inv_q;

   scrsel_resolve u_tx (
      .i_mode(i_tx_mode),
      .i_turbo_product_code_enable(i_turbo_product_code_enable),
      .i_framing_mux_enable(i_framing_mux_enable),
      .i_reed_solomon_enable(i_reed_solomon_enable),
      .i_auto_rule_set_b(i_auto_rule_set_b),
      .o_type(tx_type_c),
      .o_invert(tx_inv_c)
   );

   scrsel_resolve u_rx (
      .i_mode(i_rx_mode),
      .i_turbo_product_code_enable(i_turbo_product_code_enable),
      .i_framing_mux_enable(i_framing_mux_enable),
      .i_reed_solomon_enable(i_reed_solomon_enable),
      .i_auto_rule_set_b(i_auto_rule_set_b),
      .o_type(rx_type_c),
      .o_invert(rx_inv_c)
   );

   // Next values of the registered selections.
   always_comb begin
      tx_type_d = tx_type_c;
      rx_type_d = rx_type_c;
      tx_inv_d = tx_inv_c;
      rx_inv_d = rx_inv_c;
   end

   // Registers the selections so outputs come from flip-flops.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tx_type_q <= scrsel_pkg::SCRSEL_RESET_TYPE;
         rx_type_q <= scrsel_pkg::SCRSEL_RESET_TYPE;
         tx_inv_q <= scrsel_pkg::SCRSEL_RESET_INVERT;
         rx_inv_q <= scrsel_pkg::SCRSEL_RESET_INVERT;
      end else begin
         tx_type_q <= tx_type_d;
         rx_type_q <= rx_type_d;
         tx_inv_q <= tx_inv_d;
         rx_inv_q <= rx_inv_d;
      end
   end

   assign o_tx_type = tx_type_q;
   assign o_rx_type = rx_type_q;
   assign o_tx_invert = tx_inv_q;
   assign o_rx_invert = rx_inv_q;

   // turbo sync in auto without mux.
   a_turbo_sync_sel: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_tx_mode == scrsel_pkg::SCRSEL_MODE_AUTO && i_turbo_product_code_enable
       && !i_framing_mux_enable) |=> o_tx_type == scrsel_pkg::SCRSEL_TYPE_TURBO_SYNC)
      else $error("Turbo sync scrambler not selected.");

   // turbo with mux gives mux sync.
   a_turbo_mux_sel: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_rx_mode == scrsel_pkg::SCRSEL_MODE_AUTO && i_turbo_product_code_enable
       && i_framing_mux_enable) |=> o_rx_type == scrsel_pkg::SCRSEL_TYPE_MUX_SYNC)
      else $error("Turbo with mux did not use first rule set.");

   a_set_a_plain: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_tx_mode == scrsel_pkg::SCRSEL_MODE_RULE_A && !i_framing_mux_enable
       && !i_reed_solomon_enable) |=> o_tx_type == scrsel_pkg::SCRSEL_TYPE_SELFSYNC)
      else $error("First set without options not self-sync.");

   a_mux_sync_sel: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      ((i_tx_mode == scrsel_pkg::SCRSEL_MODE_RULE_A
        || i_tx_mode == scrsel_pkg::SCRSEL_MODE_RULE_B) && i_framing_mux_enable)
      |=> o_tx_type == scrsel_pkg::SCRSEL_TYPE_MUX_SYNC)
      else $error("Mux sync scrambler not selected.");

   a_set_a_rs: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_rx_mode == scrsel_pkg::SCRSEL_MODE_RULE_A && !i_framing_mux_enable
       && i_reed_solomon_enable) |=> o_rx_type == scrsel_pkg::SCRSEL_TYPE_RS_SYNC)
      else $error("Reed-Solomon sync scrambler not selected.");

   a_set_b_rs: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_rx_mode == scrsel_pkg::SCRSEL_MODE_RULE_B && !i_framing_mux_enable
       && i_reed_solomon_enable) |=> o_rx_type == scrsel_pkg::SCRSEL_TYPE_SELFSYNC)
      else $error("Second set with Reed-Solomon not self-sync.");

   a_auto_default: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_tx_mode == scrsel_pkg::SCRSEL_MODE_AUTO && !i_turbo_product_code_enable
       && !i_auto_rule_set_b && !i_framing_mux_enable && i_reed_solomon_enable)
      |=> o_tx_type == scrsel_pkg::SCRSEL_TYPE_RS_SYNC)
      else $error("Auto mode did not default to first set.");

   a_fixed_v35: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_tx_mode == scrsel_pkg::SCRSEL_MODE_V35)
      |=> o_tx_type == scrsel_pkg::SCRSEL_TYPE_V35 && !o_tx_invert)
      else $error("Fixed V.35 mode not honoured.");

   a_alt_invert: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      $past(i_rst_b)
      |-> o_rx_invert == ($past(i_rx_mode) == scrsel_pkg::SCRSEL_MODE_ALT_V35
                          || $past(i_rx_mode) == scrsel_pkg::SCRSEL_MODE_ALT_SELFSYNC))
      else $error("Receive inversion does not match mode.");

   // receive unaffected by transmit mode change.
   a_dir_indep: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      ($past(i_rst_b) && $stable(i_rx_mode) && $stable(i_turbo_product_code_enable)
       && $stable(i_framing_mux_enable) && $stable(i_reed_solomon_enable)
       && $stable(i_auto_rule_set_b) && $changed(i_tx_mode))
      |=> $stable(o_rx_type))
      else $error("Receive type moved with transmit mode.");

   a_rx_turbo_sync: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_rx_mode == scrsel_pkg::SCRSEL_MODE_AUTO
       && i_turbo_product_code_enable
       && !i_framing_mux_enable)
      |=> o_rx_type == scrsel_pkg::SCRSEL_TYPE_TURBO_SYNC)
      else $error("Receive turbo sync scrambler not selected.");

   a_tx_turbo_mux: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_tx_mode == scrsel_pkg::SCRSEL_MODE_AUTO
       && i_turbo_product_code_enable
       && i_framing_mux_enable)
      |=> o_tx_type == scrsel_pkg::SCRSEL_TYPE_MUX_SYNC)
      else $error("Transmit turbo with mux did not use first rule set.");

   a_rx_set_a_plain: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_rx_mode == scrsel_pkg::SCRSEL_MODE_RULE_A
       && !i_framing_mux_enable
       && !i_reed_solomon_enable)
      |=> o_rx_type == scrsel_pkg::SCRSEL_TYPE_SELFSYNC)
      else $error("Receive first set without options not self-sync.");

   a_tx_set_a_mux: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_tx_mode == scrsel_pkg::SCRSEL_MODE_RULE_A
       && i_framing_mux_enable
       && !i_reed_solomon_enable)
      |=> o_tx_type == scrsel_pkg::SCRSEL_TYPE_MUX_SYNC)
      else $error("Transmit first set with mux not mux sync.");

   a_rx_set_a_mux: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_rx_mode == scrsel_pkg::SCRSEL_MODE_RULE_A
       && i_framing_mux_enable
       && !i_reed_solomon_enable)
      |=> o_rx_type == scrsel_pkg::SCRSEL_TYPE_MUX_SYNC)
      else $error("Receive first set with mux not mux sync.");

   a_tx_set_a_rs: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_tx_mode == scrsel_pkg::SCRSEL_MODE_RULE_A
       && !i_framing_mux_enable
       && i_reed_solomon_enable)
      |=> o_tx_type == scrsel_pkg::SCRSEL_TYPE_RS_SYNC)
      else $error("Transmit Reed-Solomon sync scrambler not selected.");

   a_tx_set_a_both: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_tx_mode == scrsel_pkg::SCRSEL_MODE_RULE_A
       && i_framing_mux_enable
       && i_reed_solomon_enable)
      |=> o_tx_type == scrsel_pkg::SCRSEL_TYPE_MUX_SYNC)
      else $error("Transmit mux with Reed-Solomon not mux sync.");

   a_rx_set_a_both: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_rx_mode == scrsel_pkg::SCRSEL_MODE_RULE_A
       && i_framing_mux_enable
       && i_reed_solomon_enable)
      |=> o_rx_type == scrsel_pkg::SCRSEL_TYPE_MUX_SYNC)
      else $error("Receive mux with Reed-Solomon not mux sync.");

   a_tx_set_b_rs: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_tx_mode == scrsel_pkg::SCRSEL_MODE_RULE_B
       && !i_framing_mux_enable
       && i_reed_solomon_enable)
      |=> o_tx_type == scrsel_pkg::SCRSEL_TYPE_SELFSYNC)
      else $error("Transmit second set with Reed-Solomon not self-sync.");

   a_tx_set_b_plain: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_tx_mode == scrsel_pkg::SCRSEL_MODE_RULE_B
       && !i_framing_mux_enable
       && !i_reed_solomon_enable)
      |=> o_tx_type == scrsel_pkg::SCRSEL_TYPE_SELFSYNC)
      else $error("Transmit second set without options not self-sync.");

   a_rx_set_b_mux: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_rx_mode == scrsel_pkg::SCRSEL_MODE_RULE_B
       && i_framing_mux_enable)
      |=> o_rx_type == scrsel_pkg::SCRSEL_TYPE_MUX_SYNC)
      else $error("Receive second set with mux not mux sync.");

   // auto takes second set on request.
   a_auto_set_b: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_tx_mode == scrsel_pkg::SCRSEL_MODE_AUTO
       && !i_turbo_product_code_enable
       && i_auto_rule_set_b
       && !i_framing_mux_enable
       && i_reed_solomon_enable)
      |=> o_tx_type == scrsel_pkg::SCRSEL_TYPE_SELFSYNC)
      else $error("Auto mode did not follow the second set.");

   // receive auto defaults to first set.
   a_rx_auto_default: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_rx_mode == scrsel_pkg::SCRSEL_MODE_AUTO
       && !i_turbo_product_code_enable
       && !i_auto_rule_set_b
       && !i_framing_mux_enable
       && i_reed_solomon_enable)
      |=> o_rx_type == scrsel_pkg::SCRSEL_TYPE_RS_SYNC)
      else $error("Receive auto mode did not default to first set.");

   // auto without turbo follows a set.
   a_auto_no_turbo: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_rx_mode == scrsel_pkg::SCRSEL_MODE_AUTO
       && !i_turbo_product_code_enable
       && i_framing_mux_enable)
      |=> o_rx_type == scrsel_pkg::SCRSEL_TYPE_MUX_SYNC)
      else $error("Auto mode without turbo ignored the rule set.");

   a_tx_fixed_selfsync: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_tx_mode == scrsel_pkg::SCRSEL_MODE_SELFSYNC)
      |=> o_tx_type == scrsel_pkg::SCRSEL_TYPE_SELFSYNC && !o_tx_invert)
      else $error("Transmit fixed self-sync mode not honoured.");

   a_rx_fixed_v35: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_rx_mode == scrsel_pkg::SCRSEL_MODE_V35)
      |=> o_rx_type == scrsel_pkg::SCRSEL_TYPE_V35 && !o_rx_invert)
      else $error("Receive fixed V.35 mode not honoured.");

   a_rx_fixed_selfsync: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_rx_mode == scrsel_pkg::SCRSEL_MODE_SELFSYNC)
      |=> o_rx_type == scrsel_pkg::SCRSEL_TYPE_SELFSYNC && !o_rx_invert)
      else $error("Receive fixed self-sync mode not honoured.");

   a_alt_v35_type: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_tx_mode == scrsel_pkg::SCRSEL_MODE_ALT_V35)
      |=> o_tx_type == scrsel_pkg::SCRSEL_TYPE_V35)
      else $error("Transmit alternate V.35 mode lost its scrambler.");

   a_alt_selfsync_type: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (i_rx_mode == scrsel_pkg::SCRSEL_MODE_ALT_SELFSYNC)
      |=> o_rx_type == scrsel_pkg::SCRSEL_TYPE_SELFSYNC)
      else $error("Receive alternate self-sync mode lost its scrambler.");

   // transmit inversion exactly in alternate modes.
   // The first edge after reset still shows the reset value, so the check waits one edge.
   a_tx_alt_invert: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      $past(i_rst_b)
      |-> o_tx_invert == ($past(i_tx_mode) == scrsel_pkg::SCRSEL_MODE_ALT_V35
                          || $past(i_tx_mode) == scrsel_pkg::SCRSEL_MODE_ALT_SELFSYNC))
      else $error("Transmit inversion does not match mode.");

   // transmit unaffected by receive mode change.
   a_tx_dir_indep: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      ($past(i_rst_b) && $stable(i_tx_mode) && $stable(i_turbo_product_code_enable)
       && $stable(i_framing_mux_enable) && $stable(i_reed_solomon_enable)
       && $stable(i_auto_rule_set_b) && $changed(i_rx_mode))
      |=> $stable(o_tx_type))
      else $error("Transmit type moved with receive mode.");

endmodule // scrsel_top

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb;
   logic i_clk;
   logic i_rst_b;
   logic [2:0] i_tx_mode;
   logic [2:0] i_rx_mode;
   logic i_turbo_product_code_enable;
   logic i_framing_mux_enable;
   logic i_reed_solomon_enable;
   logic i_auto_rule_set_b;
   logic [2:0] o_tx_type;
   logic o_tx_invert;
   logic [2:0] o_rx_type;
   logic o_rx_invert;
   logic [7:0] exp_q[$];
   logic [7:0] note;
   logic [31:0] r;
   int n_mismatch;
   int checked;

   scrsel_top dut (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_tx_mode(i_tx_mode),
      .i_rx_mode(i_rx_mode),
      .i_turbo_product_code_enable(i_turbo_product_code_enable),
      .i_framing_mux_enable(i_framing_mux_enable),
      .i_reed_solomon_enable(i_reed_solomon_enable),
      .i_auto_rule_set_b(i_auto_rule_set_b),
      .o_tx_type(o_tx_type),
      .o_tx_invert(o_tx_invert),
      .o_rx_type(o_rx_type),
      .o_rx_invert(o_rx_invert)
   );

   // Expected {type, invert} for one direction, worked out independently of the design.
   function automatic logic [3:0] exp_of(input logic [2:0] mode, input logic t, m, rs, b);
      logic use_b;
      logic [2:0] ty;
      use_b = (mode == scrsel_pkg::SCRSEL_MODE_RULE_B) ||
              ((mode == scrsel_pkg::SCRSEL_MODE_AUTO) && !t && b);
      ty = m ? scrsel_pkg::SCRSEL_TYPE_MUX_SYNC :
           (rs && !use_b) ? scrsel_pkg::SCRSEL_TYPE_RS_SYNC : scrsel_pkg::SCRSEL_TYPE_SELFSYNC;
      case (mode)
         scrsel_pkg::SCRSEL_MODE_OFF: return 4'h0;
         scrsel_pkg::SCRSEL_MODE_AUTO:
            return {(t && !m) ? scrsel_pkg::SCRSEL_TYPE_TURBO_SYNC : ty, 1'b0};
         scrsel_pkg::SCRSEL_MODE_RULE_A, scrsel_pkg::SCRSEL_MODE_RULE_B: return {ty, 1'b0};
         scrsel_pkg::SCRSEL_MODE_V35: return {scrsel_pkg::SCRSEL_TYPE_V35, 1'b0};
         scrsel_pkg::SCRSEL_MODE_SELFSYNC: return {scrsel_pkg::SCRSEL_TYPE_SELFSYNC, 1'b0};
         scrsel_pkg::SCRSEL_MODE_ALT_V35: return {scrsel_pkg::SCRSEL_TYPE_V35, 1'b1};
         default: return {scrsel_pkg::SCRSEL_TYPE_SELFSYNC, 1'b1};
      endcase
   endfunction

   // Compares a resolved type.
   task automatic cmp_type(input string what, input logic [2:0] exp, input logic [2:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // Compares an inversion flag.
   task automatic cmp_inv(input string what, input logic exp, input logic got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask

   // Drives one setting at the falling edge and notes what must appear one edge later.
   task automatic drive(input logic [2:0] tm, input logic [2:0] rm, input logic [3:0] f);
      @(negedge i_clk);
      i_tx_mode = tm;
      i_rx_mode = rm;
      {i_turbo_product_code_enable, i_framing_mux_enable} = f[3:2];
      {i_reed_solomon_enable, i_auto_rule_set_b} = f[1:0];
      exp_q.push_back({exp_of(tm, f[3], f[2], f[1], f[0]), exp_of(rm, f[3], f[2], f[1], f[0])});
   endtask

   // Outputs must be cleared while reset is low.
   task automatic check_idle;
      cmp_type("tx type in reset", scrsel_pkg::SCRSEL_RESET_TYPE, o_tx_type);
      cmp_inv("tx invert in reset", scrsel_pkg::SCRSEL_RESET_INVERT, o_tx_invert);
      cmp_type("rx type in reset", scrsel_pkg::SCRSEL_RESET_TYPE, o_rx_type);
      cmp_inv("rx invert in reset", scrsel_pkg::SCRSEL_RESET_INVERT, o_rx_invert);
   endtask

   task automatic give_verdict;
      if (n_mismatch == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end

   // Takes the oldest note once the registered outputs have settled after each edge.
   initial begin
      forever begin
         @(posedge i_clk);
         #1;
         if (exp_q.size() > 0) begin
            note = exp_q.pop_front();
            cmp_type("tx type", note[7:5], o_tx_type);
            cmp_inv("tx invert", note[4], o_tx_invert);
            cmp_type("rx type", note[3:1], o_rx_type);
            cmp_inv("rx invert", note[0], o_rx_invert);
         end
      end
   end

   // Cuts a hang short.
   initial begin
      for (int k = 0; k < 5000; k++) begin
         @(posedge i_clk);
      end
      n_mismatch++;
      $display("unexpected run length: expected under 5000 cycles, seen 5000");
      give_verdict();
   end

   initial begin
      i_rst_b = 1'b0;
      {i_tx_mode, i_rx_mode} = 6'h00;
      {i_turbo_product_code_enable, i_framing_mux_enable} = 2'h0;
      {i_reed_solomon_enable, i_auto_rule_set_b} = 2'h0;
      n_mismatch = 0;
      checked = 0;
      r = $urandom(32'h40f5);
      repeat (3) @(posedge i_clk);
      #1;
      check_idle();
      @(negedge i_clk);
      i_rst_b = 1'b1;
      // Every mode against every enable combination, the two directions set differently.
      for (int m = 0; m < 8; m++) begin
         for (int f = 0; f < 16; f++) begin
            drive(m[2:0], 3'(7 - m), f[3:0]);
         end
      end
      repeat (200) begin
         r = $urandom;
         drive(r[2:0], r[5:3], r[9:6]);
      end
      // Reset in mid-run with live settings, then resume straight into turbo auto.
      @(negedge i_clk);
      i_rst_b = 1'b0;
      #1;
      check_idle();
      @(negedge i_clk);
      i_rst_b = 1'b1;
      drive(3'h1, 3'h7, 4'h8);
      drive(3'h1, 3'h1, 4'hc);
      // Move one direction's mode at a time with everything else held.
      drive(3'h4, 3'h1, 4'hc);
      drive(3'h4, 3'h2, 4'hc);
      repeat (2) @(posedge i_clk);
      #2;
      if (exp_q.size() != 0) begin
         n_mismatch++;
         $display("unexpected pending notes: expected 0, seen %0d", exp_q.size());
      end
      give_verdict();
   end
endmodule // tb
